/* File: hw/ptc_skid_buf.sv */
// Purpose: two-entry valid/ready buffer on the receive path
// Assumes: single clock, asynchronous use of the synchronised reset copy
// Notes: full and empty are exact; the drain side may stall at will
`timescale 1ns/1ps
module ptc_skid_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic in_valid_i, // word offered
  output logic in_ready_o, // room for a word
  input wire logic [W-1:0] in_data_i, // word in
  output logic out_valid_o, // word held
  input wire logic out_ready_i, // drain accepts
  output logic [W-1:0] out_data_o // oldest word
);
  // the single-bit pointers below only serve two entries
  if (DEPTH != 2) begin : g_depth_chk
    $error("ptc_skid_buf serves exactly two entries");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // pointers and storage next values
  always_comb begin
    in_ready_o = (cnt_q != 2'h2);
    out_valid_o = (cnt_q != 2'h0);
    out_data_o = mem_q[rd_q];
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q <= '{default: '0};
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule : ptc_skid_buf

/* File: hw/ptc_ts_path.sv */
// Purpose: timestamp client path: tx command field and rx timestamp delivery
// Assumes: timer inputs and start-codegroup strobes come from core_clk_i logic
// Notes: the rx path stalls its source for one cycle to insert the timestamp beat
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Functional notes
// - sideband bit 0 carries the client's underrun flag for the beat
// - sideband bits 63 to 1 are ignored
// - sideband bits 127 to 64 carry the out-of-band command word
// - sideband command used only while in-band command bit 22 is clear
// - each rx frame gets an 80-bit time value on separate ports
// - time-of-day inline value: low 32 seconds bits plus 32 nanosecond bits
// - correction format gives the 64-bit value out of band, optionally inline
// - rx time captured at the start codegroup strobe
// - rx capture reduced by a configurable latency duration
// - inline rx timestamp only while rx config bit 22 is set
// - inline timestamp is a beat ahead of the frame, replacing preamble
// - inline beat: nanoseconds in 31:0, low seconds in 63:32
// - custom preamble set disables in-band command passing
// - out-of-band rx timestamp valid with the frame's first beat (with inline timestamp on, the code flags the inline beat instead)
// - without inline timestamp the first beat holds the addresses
// - in-band command word is the beat just before the frame
// - tx time sampled at start codegroup plus configurable latency
module ptc_ts_path
  import ptc_pkg::*;
(
  input wire logic core_clk_i, // 25 MHz core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [ptc_pkg::ADDR_W-1:0] reg_addr_i, // register byte address
  input wire logic [ptc_pkg::REG_W-1:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [ptc_pkg::REG_W-1:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic [ptc_pkg::SEC_W-1:0] tod_sec_i, // timer seconds
  input wire logic [ptc_pkg::NS_W-1:0] tod_ns_i, // timer nanoseconds
  input wire logic [ptc_pkg::CF_W-1:0] cf_time_i, // correction-format timer
  input wire logic [ptc_pkg::DATA_W-1:0] s_tx_tdata_i, // client tx data
  input wire logic [ptc_pkg::KEEP_W-1:0] s_tx_tkeep_i, // client tx byte keep
  input wire logic [ptc_pkg::TUSER_W-1:0] s_tx_tuser_i, // client tx sideband
  input wire logic s_tx_tvalid_i, // client tx valid
  input wire logic s_tx_tlast_i, // client tx last
  output logic s_tx_tready_o, // client tx ready
  output logic [ptc_pkg::DATA_W-1:0] mac_tx_tdata_o, // tx data to mac
  output logic [ptc_pkg::KEEP_W-1:0] mac_tx_tkeep_o, // tx keep to mac
  output logic mac_tx_tvalid_o, // tx valid to mac
  output logic mac_tx_tlast_o, // tx last to mac
  output logic mac_tx_underrun_o, // underrun flag with the beat
  input wire logic mac_tx_tready_i, // mac accepts tx beat
  output logic [ptc_pkg::CMD_W-1:0] tx_cmd_o, // frame command word
  output logic tx_cmd_valid_o, // one-cycle pulse, new command
  input wire logic tx_sof_i, // tx start codegroup strobe
  output logic [ptc_pkg::TOD_W-1:0] tx_ts_o, // adjusted tx timestamp
  output logic tx_ts_valid_o, // one-cycle pulse
  input wire logic rx_sof_i, // rx start codegroup strobe
  input wire logic [ptc_pkg::DATA_W-1:0] rx_in_tdata_i, // rx data from mac
  input wire logic [ptc_pkg::KEEP_W-1:0] rx_in_tkeep_i, // rx keep from mac
  input wire logic rx_in_tvalid_i, // rx valid from mac
  input wire logic rx_in_tlast_i, // rx last from mac
  output logic rx_in_tready_o, // rx ready to mac
  output logic [ptc_pkg::DATA_W-1:0] m_rx_tdata_o, // rx data to client
  output logic [ptc_pkg::KEEP_W-1:0] m_rx_tkeep_o, // rx keep to client
  output logic m_rx_tvalid_o, // rx valid to client
  output logic m_rx_tlast_o, // rx last to client
  input wire logic m_rx_tready_i, // client accepts rx beat
  output logic [ptc_pkg::TOD_W-1:0] rx_ts_o, // out-of-band rx timestamp
  output logic rx_ts_valid_o // high with frame's first beat, or with its inline timestamp beat when enabled
);
  localparam int BUF_W = DATA_W + KEEP_W + 1 + 1 + TOD_W;

  // add a duration to a time-of-day value, carrying into seconds
  function automatic logic [TOD_W-1:0] tod_add(input logic [TOD_W-1:0] t,
                                               input logic [ADJ_W-1:0] a);
    logic [32:0] s;
    s = {1'b0, t[NS_W-1:0]} + {1'b0, a};
    if (s >= NS_PER_SEC) begin
      tod_add = {t[TOD_W-1:NS_W] + 48'h1, 32'(s - NS_PER_SEC)};
    end else begin
      tod_add = {t[TOD_W-1:NS_W], s[NS_W-1:0]};
    end
  endfunction : tod_add

  // subtract a duration from a time-of-day value, borrowing from seconds
  function automatic logic [TOD_W-1:0] tod_sub(input logic [TOD_W-1:0] t,
                                               input logic [ADJ_W-1:0] a);
    logic [32:0] s;
    s = {1'b0, t[NS_W-1:0]};
    if (s >= {1'b0, a}) begin
      tod_sub = {t[TOD_W-1:NS_W], 32'(s - {1'b0, a})};
    end else begin
      tod_sub = {t[TOD_W-1:NS_W] - 48'h1, 32'(s + NS_PER_SEC - {1'b0, a})};
    end
  endfunction : tod_sub

  // reset release through two flip-flops
  logic rst_s1_q, rst_n;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ---------------- register file ----------------
  logic [REG_W-1:0] tx_cfg_q, tx_cfg_d, rx_cfg_q, rx_cfg_d, fmt_q, fmt_d;
  logic [ADJ_W-1:0] tx_adj_q, tx_adj_d, rx_adj_q, rx_adj_d;
  logic [REG_W-1:0] rdata_q, rdata_d;
  logic [7:0] rx_cnt_q, rx_cnt_d;
  logic inband_bit, cust_pre, eff_inband, inline_en, cf_fmt;
  logic pend_v_q, pend_v_d;
  logic [TOD_W-1:0] pend_q, pend_d;
  logic [TOD_W-1:0] tx_ts_q, tx_ts_d;
  logic rx_first_acc;

  assign inband_bit = tx_cfg_q[INBAND_CMD_BIT];
  assign cust_pre = tx_cfg_q[CUST_PRE_BIT];
  assign eff_inband = inband_bit & ~cust_pre;
  assign inline_en = rx_cfg_q[INLINE_TS_BIT];
  assign cf_fmt = fmt_q[CF_FMT_BIT];

  // register writes and read mux; unmapped reads give zero
  always_comb begin
    tx_cfg_d = tx_cfg_q;
    rx_cfg_d = rx_cfg_q;
    fmt_d = fmt_q;
    tx_adj_d = tx_adj_q;
    rx_adj_d = rx_adj_q;
    rdata_d = '0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        TX_CFG_OFS: tx_cfg_d = reg_wdata_i;
        RX_CFG_OFS: rx_cfg_d = reg_wdata_i;
        FMT_OFS: fmt_d = reg_wdata_i;
        TX_ADJ_OFS: tx_adj_d = reg_wdata_i;
        RX_ADJ_OFS: rx_adj_d = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        TX_CFG_OFS: rdata_d = tx_cfg_q;
        RX_CFG_OFS: rdata_d = rx_cfg_q;
        FMT_OFS: rdata_d = fmt_q;
        TX_ADJ_OFS: rdata_d = tx_adj_q;
        RX_ADJ_OFS: rdata_d = rx_adj_q;
        STATUS_OFS: rdata_d = {16'h0000, rx_cnt_q, 7'h00, pend_v_q};
        TX_TS_LO_OFS: rdata_d = tx_ts_q[NS_W-1:0];
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_cfg_q <= CFG_RST;
      rx_cfg_q <= CFG_RST;
      fmt_q <= CFG_RST;
      tx_adj_q <= TX_ADJ_RST;
      rx_adj_q <= RX_ADJ_RST;
      rdata_q <= '0;
    end else begin
      tx_cfg_q <= tx_cfg_d;
      rx_cfg_q <= rx_cfg_d;
      fmt_q <= fmt_d;
      tx_adj_q <= tx_adj_d;
      rx_adj_q <= rx_adj_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata_o = rdata_q;

  // ---------------- transmit path ----------------
  ptc_tx_st_t tx_st_q, tx_st_d;
  logic tx_fire, tx_fwd, tx_oval_d, tx_oval_q;
  logic [DATA_W-1:0] tx_dat_q, tx_dat_d;
  logic [KEEP_W-1:0] tx_keep_q, tx_keep_d;
  logic tx_last_q, tx_last_d, tx_und_q, tx_und_d;
  logic [CMD_W-1:0] cmd_q, cmd_d;
  logic cmd_v_q, cmd_v_d, tx_ts_v_q, tx_ts_v_d;

  // single output stage; ready only when the stage is free or draining
  assign s_tx_tready_o = ~tx_oval_q | mac_tx_tready_i;
  assign tx_fire = s_tx_tvalid_i & s_tx_tready_o;

  // command extraction and beat forwarding
  always_comb begin
    tx_st_d = tx_st_q;
    cmd_d = cmd_q;
    cmd_v_d = 1'b0;
    tx_fwd = 1'b0;
    if (tx_fire) begin
      unique case (tx_st_q)
        PTC_TX_START: begin
          if (eff_inband) begin
            cmd_d = s_tx_tdata_i;
            cmd_v_d = 1'b1;
            tx_st_d = PTC_TX_FIRST;
          end else begin
            tx_fwd = 1'b1;
            tx_st_d = s_tx_tlast_i ? PTC_TX_START : PTC_TX_BODY;
            if (!inband_bit) begin
              cmd_d = s_tx_tuser_i[CMD_LSB +: CMD_W];
              cmd_v_d = 1'b1;
            end
          end
        end
        PTC_TX_FIRST, PTC_TX_BODY: begin
          tx_fwd = 1'b1;
          tx_st_d = s_tx_tlast_i ? PTC_TX_START : PTC_TX_BODY;
        end
        default: tx_st_d = PTC_TX_START;
      endcase
    end
    tx_oval_d = tx_fwd | (tx_oval_q & ~mac_tx_tready_i);
    tx_dat_d = tx_fwd ? s_tx_tdata_i : tx_dat_q;
    tx_keep_d = tx_fwd ? s_tx_tkeep_i : tx_keep_q;
    tx_last_d = tx_fwd ? s_tx_tlast_i : tx_last_q;
    // underrun travels with beat; bits 63:1 unread
    tx_und_d = tx_fwd ? s_tx_tuser_i[UNDERRUN_BIT] : tx_und_q;
    tx_ts_v_d = tx_sof_i;
    if (!tx_sof_i) begin
      tx_ts_d = tx_ts_q;
    end else if (cf_fmt) begin
      tx_ts_d = {16'h0000, cf_time_i + {16'h0000, tx_adj_q, 16'h0000}};
    end else begin
      tx_ts_d = tod_add({tod_sec_i, tod_ns_i}, tx_adj_q);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= PTC_TX_START;
      tx_oval_q <= 1'b0;
      tx_dat_q <= '0;
      tx_keep_q <= '0;
      tx_last_q <= 1'b0;
      tx_und_q <= 1'b0;
      cmd_q <= '0;
      cmd_v_q <= 1'b0;
      tx_ts_q <= '0;
      tx_ts_v_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_oval_q <= tx_oval_d;
      tx_dat_q <= tx_dat_d;
      tx_keep_q <= tx_keep_d;
      tx_last_q <= tx_last_d;
      tx_und_q <= tx_und_d;
      cmd_q <= cmd_d;
      cmd_v_q <= cmd_v_d;
      tx_ts_q <= tx_ts_d;
      tx_ts_v_q <= tx_ts_v_d;
    end
  end
  assign mac_tx_tvalid_o = tx_oval_q;
  assign mac_tx_tdata_o = tx_dat_q;
  assign mac_tx_tkeep_o = tx_keep_q;
  assign mac_tx_tlast_o = tx_last_q;
  assign mac_tx_underrun_o = tx_und_q;
  assign tx_cmd_o = cmd_q;
  assign tx_cmd_valid_o = cmd_v_q;
  assign tx_ts_o = tx_ts_q;
  assign tx_ts_valid_o = tx_ts_v_q;

  // ---------------- receive path ----------------
  ptc_rx_st_t rx_st_q, rx_st_d;
  logic buf_rdy, ins_beat, rx_acc, push_first;
  logic [DATA_W-1:0] push_dat, inline_word;
  logic [KEEP_W-1:0] push_keep;
  logic push_last;
  logic [BUF_W-1:0] push_word, pop_word;
  logic [TOD_W-1:0] cap_ts;

  // capture at start codegroup less rx latency
  assign cap_ts = cf_fmt ? {16'h0000, cf_time_i - {16'h0000, rx_adj_q, 16'h0000}}
                         : tod_sub({tod_sec_i, tod_ns_i}, rx_adj_q);
  // low seconds above nanoseconds; full correction value
  assign inline_word = cf_fmt ? pend_q[CF_W-1:0] : {pend_q[NS_W +: 32], pend_q[NS_W-1:0]};
  // timestamp beat only when enabled, at frame start
  assign ins_beat = (rx_st_q == PTC_RX_START) & inline_en;
  assign rx_in_tready_o = buf_rdy & ~ins_beat;
  assign rx_acc = rx_in_tvalid_i & rx_in_tready_o;
  assign rx_first_acc = rx_acc & (rx_st_q != PTC_RX_BODY);

  // beat selection into the buffer and frame tracking
  always_comb begin
    rx_st_d = rx_st_q;
    push_dat = rx_in_tdata_i;
    push_keep = rx_in_tkeep_i;
    push_last = rx_in_tlast_i;
    push_first = (rx_st_q == PTC_RX_START);
    if (ins_beat) begin
      push_dat = inline_word;
      push_keep = '1;
      push_last = 1'b0;
      if (rx_in_tvalid_i && buf_rdy) begin
        rx_st_d = PTC_RX_HDR;
      end
    end else if (rx_acc) begin
      rx_st_d = rx_in_tlast_i ? PTC_RX_START : PTC_RX_BODY;
    end
    // held until its frame's first beat enters; new capture wins
    pend_v_d = rx_sof_i | (pend_v_q & ~rx_first_acc);
    pend_d = rx_sof_i ? cap_ts : pend_q;
    rx_cnt_d = rx_cnt_q + {7'h00, rx_acc & rx_in_tlast_i};
  end
  assign push_word = {pend_q, push_first, push_last, push_keep, push_dat};

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= PTC_RX_START;
      pend_v_q <= 1'b0;
      pend_q <= '0;
      rx_cnt_q <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      pend_v_q <= pend_v_d;
      pend_q <= pend_d;
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // two-entry buffer so a client stall loses no word
  ptc_skid_buf #(.W(BUF_W), .DEPTH(2)) u_rx_buf (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(rx_in_tvalid_i),
    .in_ready_o(buf_rdy),
    .in_data_i(push_word),
    .out_valid_o(m_rx_tvalid_o),
    .out_ready_i(m_rx_tready_i),
    .out_data_o(pop_word)
  );
  assign m_rx_tdata_o = pop_word[DATA_W-1:0];
  assign m_rx_tkeep_o = pop_word[DATA_W +: KEEP_W];
  assign m_rx_tlast_o = pop_word[DATA_W+KEEP_W];
  assign rx_ts_valid_o = m_rx_tvalid_o & pop_word[DATA_W+KEEP_W+1];
  assign rx_ts_o = pop_word[BUF_W-1 -: TOD_W];

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  AST_TX_UNDERRUN: assert property (tx_fwd |=> mac_tx_underrun_o == $past(s_tx_tuser_i[0]))
    else $error("underrun flag not carried with beat");
  AST_TX_OOB_CMD: assert property ((tx_fire && tx_st_q == PTC_TX_START && !inband_bit) |=>
    (tx_cmd_valid_o && tx_cmd_o == $past(s_tx_tuser_i[127:64])))
    else $error("sideband command not taken");
  AST_TX_NO_OOB: assert property (inband_bit |-> ##1 !(tx_cmd_valid_o &&
    $past(tx_fwd) && $past(tx_st_q) == PTC_TX_START))
    else $error("sideband command used with in-band bit set");
  AST_TX_IB_CMD: assert property ((tx_fire && tx_st_q == PTC_TX_START && eff_inband) |=>
    (tx_cmd_o == $past(s_tx_tdata_i) && tx_st_q == PTC_TX_FIRST && !$rose(mac_tx_tvalid_o)))
    else $error("in-band command beat mishandled");
  AST_TX_PRE_WINS: assert property (cust_pre |-> tx_st_q != PTC_TX_FIRST ##1 1'b1)
    else $error("in-band command honoured under custom preamble");
  AST_TX_TS: assert property (tx_sof_i |=> tx_ts_valid_o ##1 !tx_ts_valid_o || $past(tx_sof_i))
    else $error("tx timestamp pulse wrong");
  AST_RX_CAPTURE: assert property (rx_sof_i |=> (pend_v_q && pend_q == $past(cap_ts)))
    else $error("rx capture not adjusted");
  AST_RX_NS_RANGE: assert property ((pend_v_q && !cf_fmt) |-> {1'b0, pend_q[31:0]} < NS_PER_SEC)
    else $error("rx nanoseconds out of range");
  AST_RX_INLINE: assert property ((ins_beat && rx_in_tvalid_i && buf_rdy && !cf_fmt) |->
    (push_dat[31:0] == pend_q[31:0] && push_dat[63:32] == pend_q[63:32] && !rx_in_tready_o))
    else $error("inline beat layout wrong");
  AST_RX_NO_INLINE: assert property ((!inline_en && rx_st_q == PTC_RX_START) |->
    (rx_in_tready_o == buf_rdy && push_dat == rx_in_tdata_i))
    else $error("first beat not the address beat");
  AST_RX_TS_ALIGN: assert property ((rx_ts_valid_o && !m_rx_tready_i) |=>
    (rx_ts_valid_o && $stable(rx_ts_o)))
    else $error("rx timestamp dropped before its first beat was taken");
  AST_RX_HOLD: assert property ((pend_v_q && !rx_sof_i && !rx_first_acc) |=>
    (pend_v_q && $stable(pend_q)))
    else $error("pending rx timestamp lost");
  COV_TX_INBAND: cover property (tx_fire && tx_st_q == PTC_TX_START && eff_inband);
  COV_RX_INLINE: cover property (ins_beat && rx_in_tvalid_i && buf_rdy);
  COV_RX_STALL: cover property (m_rx_tvalid_o && !m_rx_tready_i && !buf_rdy);
  COV_TX_TS: cover property (tx_ts_valid_o && cf_fmt);
endmodule : ptc_ts_path

/* File: shared/ptc_pkg.sv */
// Purpose: constants shared by the timestamp client path, its client model and its test
// Assumes: one 25 MHz core clock, plain register port with 32-bit data
// Notes: durations are in nanoseconds; correction values are ns scaled by 2^16
package ptc_pkg;
  // stream and timer widths
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int TUSER_W = 128;
  localparam int CMD_W = 64;
  localparam int SEC_W = 48;
  localparam int NS_W = 32;
  localparam int TOD_W = 80;
  localparam int CF_W = 64;
  localparam int ADJ_W = 32;
  localparam int CF_FRAC_BITS = 16;
  // sideband field positions
  localparam int UNDERRUN_BIT = 0;
  localparam int CMD_LSB = 64;
  // register port
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam logic [7:0] TX_CFG_OFS = 8'h00;
  localparam logic [7:0] RX_CFG_OFS = 8'h04;
  localparam logic [7:0] FMT_OFS = 8'h08;
  localparam logic [7:0] TX_ADJ_OFS = 8'h0C;
  localparam logic [7:0] RX_ADJ_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] TX_TS_LO_OFS = 8'h18;
  // configuration bit positions
  localparam int INBAND_CMD_BIT = 22;
  localparam int CUST_PRE_BIT = 23;
  localparam int INLINE_TS_BIT = 22;
  localparam int CF_FMT_BIT = 0;
  // values after reset
  localparam logic [31:0] TX_ADJ_RST = 32'h0000_0000;
  localparam logic [31:0] RX_ADJ_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // one second in nanoseconds
  localparam logic [32:0] NS_PER_SEC = 33'h0_3B9A_CA00;
  typedef enum logic [1:0] {PTC_TX_START, PTC_TX_FIRST, PTC_TX_BODY} ptc_tx_st_t;
  typedef enum logic [1:0] {PTC_RX_START, PTC_RX_HDR, PTC_RX_BODY} ptc_rx_st_t;
endpackage : ptc_pkg

/* File: verif/ptc_client_model.sv */
// Purpose: receive-side client that drains the timestamp path
// Assumes: one core clock, beats logged in order of acceptance
// Notes: hold stops the drain outright; slow takes every second cycle
`timescale 1ns/1ps
module ptc_client_model
  import ptc_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // reset, active low
  input wire logic hold_i, // refuse every beat
  input wire logic slow_i, // accept on alternate cycles
  input wire logic [ptc_pkg::DATA_W-1:0] tdata_i, // beat data
  input wire logic tvalid_i, // beat offered
  input wire logic ts_valid_i, // timestamp flag
  input wire logic [ptc_pkg::TOD_W-1:0] ts_i, // side timestamp
  output logic tready_o, // drain accepts
  output int cnt_o // beats taken
);
  logic tog_q;
  logic [DATA_W-1:0] data_q [0:15];
  logic tsv_q [0:15];
  logic [TOD_W-1:0] ts_q [0:15];
  // stalls come from hold or the slow toggle, never from the beat itself
  assign tready_o = !hold_i && (!slow_i || tog_q);
  // log the first 16 accepted beats with their side timestamps
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_q <= 1'b0;
      cnt_o <= 0;
    end else begin
      tog_q <= !tog_q;
      if (tvalid_i && tready_o && cnt_o < 16) begin
        data_q[cnt_o] <= tdata_i;
        tsv_q[cnt_o] <= ts_valid_i;
        ts_q[cnt_o] <= ts_i;
        cnt_o <= cnt_o + 1;
      end
    end
  end
endmodule : ptc_client_model

/* File: verif/test_ptc_ts_path.sv */
// Purpose: directed test of the tx command and rx timestamp paths
// Assumes: mac tx side ready except in the stall test, timer held at 5 s 1000 ns
// Notes: rx beats are checked from the client model's log
`timescale 1ns/1ps
module test_ptc_ts_path;
  import ptc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, txv = 1'b0, txs = 1'b0, rxs = 1'b0;
  logic rxv = 1'b0, rxl = 1'b0, hold = 1'b0, slow = 1'b0, rxr, mrv, mrtv, mrr;
  logic mtr = 1'b1, txr;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rv;
  logic [63:0] txd = 64'h0, rxd = 64'h0, mrd, mtd;
  logic [127:0] txu = 128'h0;
  logic [79:0] txts, mrts;
  logic [63:0] txcmd, cft = 64'h0;
  logic cmdv, tsv, mtv, mun;
  int cnt, n_fail = 0, checks = 0;
  always #20 clk = !clk;
  ptc_ts_path i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .tod_sec_i(48'h5), .tod_ns_i(32'd1000),
    .cf_time_i(cft), .s_tx_tdata_i(txd), .s_tx_tkeep_i(8'hFF), .s_tx_tuser_i(txu),
    .s_tx_tvalid_i(txv), .s_tx_tlast_i(1'b1), .s_tx_tready_o(txr), .mac_tx_tdata_o(mtd),
    .mac_tx_tkeep_o(), .mac_tx_tvalid_o(mtv), .mac_tx_tlast_o(), .mac_tx_underrun_o(mun),
    .mac_tx_tready_i(mtr), .tx_cmd_o(txcmd), .tx_cmd_valid_o(cmdv), .tx_sof_i(txs),
    .tx_ts_o(txts), .tx_ts_valid_o(tsv), .rx_sof_i(rxs), .rx_in_tdata_i(rxd),
    .rx_in_tkeep_i(8'hFF), .rx_in_tvalid_i(rxv), .rx_in_tlast_i(rxl), .rx_in_tready_o(rxr),
    .m_rx_tdata_o(mrd), .m_rx_tkeep_o(), .m_rx_tvalid_o(mrv), .m_rx_tlast_o(),
    .m_rx_tready_i(mrr), .rx_ts_o(mrts), .rx_ts_valid_o(mrtv));
  ptc_client_model i_cli (.clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .slow_i(slow),
    .tdata_i(mrd), .tvalid_i(mrv), .ts_valid_i(mrtv), .ts_i(mrts), .tready_o(mrr), .cnt_o(cnt));
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input string nm, input logic [79:0] e, input logic [79:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdat;
  endtask : reg_rd
  // the output stage is empty at each call, so the client beat is taken at the task's second edge, the first at which it is offered
  task automatic tx_beat(input logic [63:0] d, input logic [127:0] u);
    @(posedge clk) {txv, txd, txu} <= {1'b1, d, u};
    @(posedge clk) txv <= 1'b0;
    #1;
  endtask : tx_beat
  // one-cycle start codegroup strobe on the rx or the tx side
  task automatic pulse(input bit on_rx);
    @(posedge clk);
    if (on_rx) rxs <= 1'b1;
    else txs <= 1'b1;
    @(posedge clk);
    {rxs, txs} <= 2'b00;
    #1;
  endtask : pulse
  // ready is settled at the falling edge and holds until the next rise
  task automatic rx_beat(input logic [63:0] d, input logic l);
    int i;
    @(posedge clk) {rxv, rxd, rxl} <= {1'b1, d, l};
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (rxr === 1'b1) break;
    end
    if (i == 40) begin
      n_fail++;
      finish_test();
    end
    @(posedge clk) rxv <= 1'b0;
  endtask : rx_beat
  task automatic wait_cnt(input int n);
    int i;
    for (i = 0; i < 60 && cnt != n; i++) @(posedge clk);
    if (cnt != n) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_cnt
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_rd(STATUS_OFS, rv);
    cmp("status", 0, rv);
    reg_rd(8'hFC, rv);
    cmp("unmapped", 0, rv);
    $display("test registers done");
    tx_beat(64'hA1, {64'h1122_3344_5566_7788, 63'h5A5A_0F0F_F0F0_A5A5, 1'b1});
    cmp("cmd valid", 1, cmdv);
    cmp("cmd oob", 64'h1122_3344_5566_7788, txcmd);
    cmp("underrun", 1, mun);
    cmp("tx data", 64'hA1, mtd);
    reg_wr(TX_CFG_OFS, 32'h0040_0000);
    tx_beat(64'hC0DE_0001, {64'h99, 64'h0});
    cmp("cmd inband", 64'hC0DE_0001, txcmd);
    cmp("cmd beat held", 0, mtv);
    tx_beat(64'hB2, 128'h0);
    cmp("tx data ib", 64'hB2, mtd);
    reg_wr(TX_CFG_OFS, 32'h00C0_0000);
    tx_beat(64'hB3, {64'h77, 64'h0});
    cmp("no cmd", 0, cmdv);
    cmp("preamble fwd", 64'hB3, mtd);
    reg_wr(TX_ADJ_OFS, 32'd100);
    pulse(1'b0);
    cmp("tx ts valid", 1, tsv);
    cmp("tx ts", {48'h5, 32'd1100}, txts);
    $display("test transmit done");
    reg_wr(RX_ADJ_OFS, 32'd20);
    hold <= 1'b1;
    pulse(1'b1);
    rx_beat(64'hD1, 1'b0);
    rx_beat(64'hD2, 1'b0);
    @(negedge clk) cmp("buffer full", 0, rxr);
    @(posedge clk) hold <= 1'b0;
    rx_beat(64'hD3, 1'b1);
    wait_cnt(3);
    cmp("rx first", 64'hD1, i_cli.data_q[0]);
    cmp("rx ts flag", 1, i_cli.tsv_q[0]);
    cmp("rx ts", {48'h5, 32'd980}, i_cli.ts_q[0]);
    cmp("rx flag 2", 0, i_cli.tsv_q[1]);
    cmp("rx third", 64'hD3, i_cli.data_q[2]);
    $display("test receive plain done");
    reg_wr(RX_CFG_OFS, 32'h0040_0000);
    slow <= 1'b1;
    pulse(1'b1);
    rx_beat(64'hE1, 1'b0);
    rx_beat(64'hE2, 1'b1);
    wait_cnt(6);
    cmp("inline beat", {32'h5, 32'd980}, i_cli.data_q[3]);
    cmp("inline flag", 1, i_cli.tsv_q[3]);
    cmp("frame after", 64'hE1, i_cli.data_q[4]);
    cmp("frame flag", 0, i_cli.tsv_q[4]);
    cmp("frame end", 64'hE2, i_cli.data_q[5]);
    $display("test receive inline done");
    reg_wr(FMT_OFS, 32'h0000_0001);
    cft <= 64'h0000_0001_0000_0000;
    pulse(1'b0);
    cmp("cf tx ts", {16'h0, 64'h0000_0001_0064_0000}, txts);
    pulse(1'b1);
    rx_beat(64'hF1, 1'b1);
    wait_cnt(8);
    cmp("cf inline", 64'h0000_0000_FFEC_0000, i_cli.data_q[6]);
    cmp("cf oob ts", {16'h0, 64'h0000_0000_FFEC_0000}, i_cli.ts_q[6]);
    cmp("cf frame", 64'hF1, i_cli.data_q[7]);
    reg_rd(STATUS_OFS, rv);
    cmp("status frames", 32'h0000_0300, rv);
    $display("test correction format done");
    @(posedge clk) mtr <= 1'b0;
    tx_beat(64'hB4, {64'h0, 64'h1});
    cmp("tx ready stall", 0, txr);
    @(posedge clk) mtr <= 1'b1;
    #1 cmp("tx held", 64'hB4, mtd);
    cmp("tx valid held", 1, mtv);
    cmp("underrun held", 1, mun);
    $display("test transmit stall done");
    finish_test();
  end
endmodule : test_ptc_ts_path
